/* src/tmc_timer.sv */
// two-channel 16-bit interval timer with square wave output and register port
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
module tmc_timer
   import tmc_pkg::*;
#(
   parameter int CW = CNT_W
) (
   input wire logic SYS_CLK_I,
   input wire logic RST_I,
   input wire logic [ADDR_W-1:0] ADDR_I,
   input wire logic [31:0] WR_DATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [31:0] RD_DATA_O,
   input wire logic [NUM_CH-1:0] EVENT_IN_PIN_I,
   input wire logic WATCH_TIMER_IRQ_I,
   output logic [NUM_CH-1:0] TIMER_OUT_PIN_O,
   output logic [NUM_CH-1:0] MATCH_IRQ_A_O,
   output logic [NUM_CH-1:0] MATCH_IRQ_B_O,
   output logic IRQ_O
);

   // -------------------------------------------------------------------------
   // elaboration check and helpers
   // -------------------------------------------------------------------------
   if (CW < 2 || CW > 32) begin : g_bad_width
      $error("counter width must be 2 to 32");
   end
   // address of a per-channel register
   function automatic logic [ADDR_W-1:0] ch_addr(input int ch, input logic [7:0] off);
      ch_addr = ADDR_W'(CH_STRIDE * ch) + off;
   endfunction

   // one-cycle tick every 2**k cycles of fxx
   function automatic logic div_tick(input logic [PRE_W-1:0] pre, input int k);
      logic [PRE_W-1:0] m;
      m = PRE_W'((1 << k) - 1);
      div_tick = ((pre & m) == m);
   endfunction

   // count clock selection from range bit and two-bit clock code
   function automatic logic sel_tick(input int ch, input logic rng, input logic [1:0] code,
                                     input logic [PRE_W-1:0] pre, input logic ext,
                                     input logic wt);
      sel_tick = 1'b0;
      if (ch == 0) begin
         case ({rng, code})
            3'h0: sel_tick = div_tick(pre, CH0_DIV_0);
            3'h1: sel_tick = div_tick(pre, CH0_DIV_1);
            3'h2: sel_tick = div_tick(pre, CH0_DIV_2);
            3'h3: sel_tick = ext;
            3'h4: sel_tick = div_tick(pre, CH0_DIV_4);
            3'h5: sel_tick = div_tick(pre, CH0_DIV_5);
            3'h6: sel_tick = div_tick(pre, CH0_DIV_6);
            default: sel_tick = 1'b0; // prohibited code
         endcase
      end else begin
         case ({rng, code})
            3'h0: sel_tick = div_tick(pre, CH1_DIV_0);
            3'h1: sel_tick = div_tick(pre, CH1_DIV_1);
            3'h2: sel_tick = wt;
            3'h3: sel_tick = ext;
            3'h4: sel_tick = div_tick(pre, CH1_DIV_4);
            3'h5: sel_tick = div_tick(pre, CH1_DIV_5);
            3'h6: sel_tick = div_tick(pre, CH1_DIV_6);
            default: sel_tick = 1'b0; // prohibited code
         endcase
      end
   endfunction

   // -------------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------------
   logic [1:0] mode_q [NUM_CH], presc_q [NUM_CH];
   logic [CW-1:0] cmpa_q [NUM_CH], cmpb_q [NUM_CH], cnt_q [NUM_CH];
   logic [NUM_CH-1:0] oe_q, tog_a_q, tog_b_q, clksel_q, lvl_q, pin_q, irq_a_q, irq_b_q;
   logic [NUM_CH-1:0] ev_s1_q, ev_s2_q, ev_s3_q, ev_lvl_q, ev_edge;
   logic [NUM_CH-1:0] run, tick, match_a, match_b, lvl_set, lvl_rst;
   logic [2*NUM_CH-1:0] sts_q, mask_q, sts_set;
   logic [PRE_W-1:0] pre_q;
   logic [31:0] rdata_q, rd_mux;

   // -------------------------------------------------------------------------
   // free-running prescaler and event pin synchronisers
   // -------------------------------------------------------------------------
   // prescaler runs on fxx, dividers tap its low bits
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         pre_q <= RST_PRE;
      end else begin
         pre_q <= pre_q + 1'b1;
      end
   end

   // three-stage pin synchroniser, level accepted once stages two and three agree
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         ev_s1_q <= '0;
         ev_s2_q <= '0;
         ev_s3_q <= '0;
         ev_lvl_q <= '0;
      end else begin
         ev_s1_q <= EVENT_IN_PIN_I;
         ev_s2_q <= ev_s1_q;
         ev_s3_q <= ev_s2_q;
         for (int c = 0; c < NUM_CH; c++) begin
            if (ev_s2_q[c] == ev_s3_q[c]) begin
               ev_lvl_q[c] <= ev_s3_q[c];
            end
         end
      end
   end

   // rising edge of the filtered level; slow pulses are the source's duty
   assign ev_edge = ev_s2_q & ev_s3_q & ~ev_lvl_q;

   // -------------------------------------------------------------------------
   // count clock, match detection and level triggers
   // -------------------------------------------------------------------------
   always_comb begin
      for (int c = 0; c < NUM_CH; c++) begin
         run[c] = (mode_q[c] == MODE_CLR_ON_A);
         tick[c] = run[c] & sel_tick(c, clksel_q[c], presc_q[c], pre_q, ev_edge[c],
                                     WATCH_TIMER_IRQ_I);
         match_a[c] = tick[c] & (cnt_q[c] == cmpa_q[c]);
         match_b[c] = tick[c] & (cnt_q[c] == cmpb_q[c]);
         lvl_set[c] = WR_I & (ADDR_I == ch_addr(c, OFF_OUTCTL)) & WR_DATA_I[LVL_SET_BIT] &
                      ~WR_DATA_I[LVL_RST_BIT];
         lvl_rst[c] = WR_I & (ADDR_I == ch_addr(c, OFF_OUTCTL)) & WR_DATA_I[LVL_RST_BIT] &
                      ~WR_DATA_I[LVL_SET_BIT];
         sts_set[2*c] = match_a[c];
         sts_set[2*c+1] = match_b[c];
      end
   end

   // -------------------------------------------------------------------------
   // counters
   // -------------------------------------------------------------------------
   // stopped counter sits at zero, so counting starts on the first count clock
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         for (int c = 0; c < NUM_CH; c++) begin
            cnt_q[c] <= '0;
         end
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            if (!run[c]) begin
               cnt_q[c] <= '0;
            end else if (match_a[c]) begin
               cnt_q[c] <= '0;
            end else if (tick[c]) begin
               cnt_q[c] <= cnt_q[c] + 1'b1;
            end
         end
      end
   end

   // -------------------------------------------------------------------------
   // configuration registers
   // -------------------------------------------------------------------------
   // software writes; prescaler is not guarded while counting
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         for (int c = 0; c < NUM_CH; c++) begin
            mode_q[c] <= RST_MODE;
            presc_q[c] <= RST_PRESC;
            cmpa_q[c] <= '0;
            cmpb_q[c] <= '0;
         end
         {tog_b_q, tog_a_q, oe_q} <= {NUM_CH{RST_OUTCTL}};
         clksel_q <= RST_CLKSEL;
         mask_q <= RST_IRQ;
      end else if (WR_I) begin
         for (int c = 0; c < NUM_CH; c++) begin
            if (ADDR_I == ch_addr(c, OFF_MODE)) begin
               mode_q[c] <= WR_DATA_I[MODE_LSB +: 2];
            end
            if (ADDR_I == ch_addr(c, OFF_PRESC)) begin
               presc_q[c] <= WR_DATA_I[1:0];
            end
            if (ADDR_I == ch_addr(c, OFF_OUTCTL)) begin
               oe_q[c] <= WR_DATA_I[OUT_EN_BIT];
               tog_a_q[c] <= WR_DATA_I[TOG_A_BIT];
               tog_b_q[c] <= WR_DATA_I[TOG_B_BIT];
            end
            if (ADDR_I == ch_addr(c, OFF_CMPA)) begin
               cmpa_q[c] <= WR_DATA_I[CW-1:0];
            end
            if (ADDR_I == ch_addr(c, OFF_CMPB)) begin
               cmpb_q[c] <= WR_DATA_I[CW-1:0];
            end
         end
         if (ADDR_I == OFF_CLKSEL) begin
            clksel_q <= WR_DATA_I[NUM_CH-1:0];
         end
         if (ADDR_I == OFF_IRQ_MASK) begin
            mask_q <= WR_DATA_I[2*NUM_CH-1:0];
         end
      end
   end

   // -------------------------------------------------------------------------
   // timer output pins
   // -------------------------------------------------------------------------
   // level triggers take priority over a toggle in the same cycle
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         lvl_q <= '0;
         pin_q <= '0;
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            if (lvl_set[c]) begin
               lvl_q[c] <= 1'b1;
            end else if (lvl_rst[c]) begin
               lvl_q[c] <= 1'b0;
            end else if ((match_a[c] & tog_a_q[c]) | (match_b[c] & tog_b_q[c])) begin
               lvl_q[c] <= ~lvl_q[c];
            end
         end
         pin_q <= oe_q & lvl_q;
      end
   end

   // -------------------------------------------------------------------------
   // interrupts
   // -------------------------------------------------------------------------
   // raw match pulses go to the interrupt controller unmasked
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         irq_a_q <= '0;
         irq_b_q <= '0;
      end else begin
         irq_a_q <= match_a;
         irq_b_q <= match_b;
      end
   end

   // sticky status, write one to clear, a new event wins over the clear
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         sts_q <= RST_IRQ;
      end else if (WR_I && ADDR_I == OFF_IRQ_STS) begin
         sts_q <= (sts_q & ~WR_DATA_I[2*NUM_CH-1:0]) | sts_set;
      end else begin
         sts_q <= sts_q | sts_set;
      end
   end

   // -------------------------------------------------------------------------
   // read port
   // -------------------------------------------------------------------------
   // unmapped addresses and trigger bits read as zero
   always_comb begin
      rd_mux = '0;
      for (int c = 0; c < NUM_CH; c++) begin
         if (ADDR_I == ch_addr(c, OFF_MODE)) begin
            rd_mux = 32'(mode_q[c]) << MODE_LSB;
         end
         if (ADDR_I == ch_addr(c, OFF_PRESC)) begin
            rd_mux = 32'(presc_q[c]);
         end
         if (ADDR_I == ch_addr(c, OFF_OUTCTL)) begin
            rd_mux = (32'(tog_b_q[c]) << TOG_B_BIT) | (32'(tog_a_q[c]) << TOG_A_BIT) |
                     32'(oe_q[c]);
         end
         if (ADDR_I == ch_addr(c, OFF_CMPA)) begin
            rd_mux = 32'(cmpa_q[c]);
         end
         if (ADDR_I == ch_addr(c, OFF_CMPB)) begin
            rd_mux = 32'(cmpb_q[c]);
         end
         if (ADDR_I == ch_addr(c, OFF_COUNT)) begin
            rd_mux = 32'(cnt_q[c]);
         end
      end
      if (ADDR_I == OFF_CLKSEL) begin
         rd_mux = 32'(clksel_q);
      end
      if (ADDR_I == OFF_IRQ_STS) begin
         rd_mux = 32'(sts_q);
      end
      if (ADDR_I == OFF_IRQ_MASK) begin
         rd_mux = 32'(mask_q);
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= RD_I ? rd_mux : 32'h00000000;
      end
   end

   assign RD_DATA_O = rdata_q;
   assign TIMER_OUT_PIN_O = pin_q;
   assign MATCH_IRQ_A_O = irq_a_q;
   assign MATCH_IRQ_B_O = irq_b_q;
   assign IRQ_O = |(sts_q & mask_q);

   // -------------------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------------------
   for (genvar g = 0; g < NUM_CH; g++) begin : g_chk
      property p_clear_on_a;
         @(posedge SYS_CLK_I) disable iff (RST_I)
         match_a[g] |=> cnt_q[g] == '0;
      endproperty
      a_clear_on_a: assert property (p_clear_on_a) else $error("no clear on match a");
      property p_step;
         @(posedge SYS_CLK_I) disable iff (RST_I)
         (run[g] && tick[g] && !match_a[g]) ##1 run[g] |-> cnt_q[g] == $past(cnt_q[g]) + 1'b1;
      endproperty
      a_step: assert property (p_step) else $error("count did not step by one");
      property p_hold;
         @(posedge SYS_CLK_I) disable iff (RST_I)
         (run[g] && !tick[g]) ##1 run[g] |-> $stable(cnt_q[g]);
      endproperty
      a_hold: assert property (p_hold) else $error("count moved without tick");
      property p_stopped;
         @(posedge SYS_CLK_I) disable iff (RST_I)
         !run[g] |=> cnt_q[g] == '0 && !MATCH_IRQ_B_O[g] ##1 !MATCH_IRQ_A_O[g] || run[g];
      endproperty
      a_stopped: assert property (p_stopped) else $error("stopped channel counted");
      property p_pin_low;
         @(posedge SYS_CLK_I) disable iff (RST_I)
         !oe_q[g] |=> !TIMER_OUT_PIN_O[g];
      endproperty
      a_pin_low: assert property (p_pin_low) else $error("pin high while disabled");
      property p_toggle;
         @(posedge SYS_CLK_I) disable iff (RST_I)
         (match_a[g] && tog_a_q[g] && !match_b[g] && !lvl_set[g] && !lvl_rst[g])
            |=> lvl_q[g] != $past(lvl_q[g]);
      endproperty
      a_toggle: assert property (p_toggle) else $error("pin level not toggled");
      property p_irq_a;
         @(posedge SYS_CLK_I) disable iff (RST_I)
         match_a[g] |=> MATCH_IRQ_A_O[g] && sts_q[2*g];
      endproperty
      a_irq_a: assert property (p_irq_a) else $error("match irq a missing");
      property p_irq_b;
         @(posedge SYS_CLK_I) disable iff (RST_I)
         match_b[g] |=> MATCH_IRQ_B_O[g] && sts_q[2*g+1];
      endproperty
      a_irq_b: assert property (p_irq_b) else $error("match irq b missing");
      property p_read_count;
         @(posedge SYS_CLK_I) disable iff (RST_I)
         (RD_I && ADDR_I == ch_addr(g, OFF_COUNT)) |=> RD_DATA_O == 32'($past(cnt_q[g]));
      endproperty
      a_read_count: assert property (p_read_count) else $error("count read wrong");
      property p_no_clock;
         @(posedge SYS_CLK_I) disable iff (RST_I)
         (clksel_q[g] && presc_q[g] == CODE_EXT) |-> !tick[g];
      endproperty
      a_no_clock: assert property (p_no_clock) else $error("prohibited code ticked");
   end

   property p_half_rate;
      @(posedge SYS_CLK_I) disable iff (RST_I)
      (tick[0] && !clksel_q[0] && presc_q[0] == 2'h0) ##1 (presc_q[0] == 2'h0)
         |-> !tick[0] ##1 tick[0] || !run[0];
   endproperty
   a_half_rate: assert property (p_half_rate) else $error("fxx/2 rate wrong");
endmodule

/* src/tmc_pkg.sv */
// constants and register map of the two-channel interval / square wave timer
// -----------------------------------------------------------------------------
// Notes on behaviour
// - count clock from two select bits plus range bit
// - channel 0 clock table, code 111 gives no clock
// - channel 1 clock table, code 111 gives no clock
// - mode 11 counts, synchronised to count clock
// - match with compare a clears count, raises irq
// - match interval is compare a plus one
// - compare b match always raises its irq
// - reading count register returns current count
// - compare a match toggles pin when enabled
// - output disabled holds pin low
// - match irq a independent of toggle enable
// -----------------------------------------------------------------------------
package tmc_pkg;
   localparam int NUM_CH = 2;
   localparam int CNT_W = 16;
   localparam int PRE_W = 7;
   localparam int ADDR_W = 8;
   // register byte offsets inside one channel and channel stride
   localparam logic [7:0] OFF_MODE = 8'h00;
   localparam logic [7:0] OFF_PRESC = 8'h04;
   localparam logic [7:0] OFF_OUTCTL = 8'h08;
   localparam logic [7:0] OFF_CMPA = 8'h0C;
   localparam logic [7:0] OFF_CMPB = 8'h10;
   localparam logic [7:0] OFF_COUNT = 8'h14;
   localparam logic [7:0] CH_STRIDE = 8'h20;
   // shared registers
   localparam logic [7:0] OFF_CLKSEL = 8'h40;
   localparam logic [7:0] OFF_IRQ_STS = 8'h44;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h48;
   // field positions
   localparam int MODE_LSB = 2;
   localparam int OUT_EN_BIT = 0;
   localparam int TOG_A_BIT = 1;
   localparam int LVL_RST_BIT = 2;
   localparam int LVL_SET_BIT = 3;
   localparam int TOG_B_BIT = 4;
   // mode and clock codes
   localparam logic [1:0] MODE_CLR_ON_A = 2'h3;
   localparam logic [1:0] CODE_EXT = 2'h3;
   // power-of-two dividers of fxx per clock code
   localparam int CH0_DIV_0 = 1;
   localparam int CH0_DIV_1 = 2;
   localparam int CH0_DIV_2 = 3;
   localparam int CH0_DIV_4 = 5;
   localparam int CH0_DIV_5 = 6;
   localparam int CH0_DIV_6 = 7;
   localparam int CH1_DIV_0 = 0;
   localparam int CH1_DIV_1 = 2;
   localparam int CH1_DIV_4 = 1;
   localparam int CH1_DIV_5 = 3;
   localparam int CH1_DIV_6 = 4;
   // values after reset
   localparam logic [1:0] RST_MODE = 2'h0;
   localparam logic [1:0] RST_PRESC = 2'h0;
   localparam logic [1:0] RST_CLKSEL = 2'h0;
   localparam logic [2:0] RST_OUTCTL = 3'h0;
   localparam logic [3:0] RST_IRQ = 4'h0;
   localparam logic [PRE_W-1:0] RST_PRE = 7'h00;
endpackage

/* verification/tmc_far_side.sv */
// far-side model: external event source, watch timer and interrupt controller
`timescale 1ns/100ps
module tmc_far_side
   import tmc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [NUM_CH-1:0] match_a_i,
   input wire logic [NUM_CH-1:0] match_b_i,
   output logic [NUM_CH-1:0] event_pin_o,
   output logic watch_irq_o
);
   int cnt_a[NUM_CH];
   int cnt_b[NUM_CH];

   // event pins idle low, watch timer quiet until asked
   initial begin
      event_pin_o = '0;
      watch_irq_o = 1'b0;
   end

   // interrupt controller side: count every match pulse per channel
   always @(posedge clk_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
         if (rst_i === 1'b0 && match_a_i[c] === 1'b1) cnt_a[c]++;
         if (rst_i === 1'b0 && match_b_i[c] === 1'b1) cnt_b[c]++;
      end
   end

   // one watch timer pulse, one cycle long
   task automatic watch_tick;
      @(posedge clk_i);
      watch_irq_o <= 1'b1;
      @(posedge clk_i);
      watch_irq_o <= 1'b0;
   endtask

   // each level held at least 10 cycles, well beyond two fxx/4 periods
   task automatic event_pulses(input int ch, input int n);
      repeat (n) begin
         @(posedge clk_i);
         event_pin_o[ch] <= 1'b1;
         repeat (10) @(posedge clk_i);
         event_pin_o[ch] <= 1'b0;
         repeat (10) @(posedge clk_i);
      end
   endtask
endmodule

/* verification/tmc_timer_bench.sv */
// self-checking bench for the two-channel interval timer
`timescale 1ns/100ps
module tmc_timer_bench;
   import tmc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [ADDR_W-1:0] addr = '0;
   logic [31:0] wdata = '0;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [31:0] rdata;
   logic [NUM_CH-1:0] ev_pin, tout, irq_a, irq_b;
   logic wt_irq, irq;
   int err_count = 0;
   int comparisons = 0;
   int cyc = 0;
   int d0[7] = '{2, 4, 8, 0, 32, 64, 128};
   int d1[7] = '{1, 4, 0, 0, 2, 8, 16};

   // 100 MHz clock and cycle counter
   always #5 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;

   tmc_timer uut (
      .SYS_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WR_DATA_I(wdata),
      .WR_I(wr_en), .RD_I(rd_en), .RD_DATA_O(rdata), .EVENT_IN_PIN_I(ev_pin),
      .WATCH_TIMER_IRQ_I(wt_irq), .TIMER_OUT_PIN_O(tout), .MATCH_IRQ_A_O(irq_a),
      .MATCH_IRQ_B_O(irq_b), .IRQ_O(irq)
   );

   tmc_far_side far (
      .clk_i(clk), .rst_i(rst), .match_a_i(irq_a), .match_b_i(irq_b),
      .event_pin_o(ev_pin), .watch_irq_o(wt_irq)
   );

   // -------------------------------------------------------------------------
   // bus and compare helpers
   // -------------------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 check(rdata, exp, what);
   endtask

   function automatic logic [7:0] base(input int ch);
      return (ch != 0) ? CH_STRIDE : 8'h00;
   endfunction

   // stop the channel before touching its clock, then start it
   task automatic setup(input int ch, input logic [2:0] code, input logic [15:0] m,
                        input logic [15:0] mb, input logic [7:0] oc);
      wr(base(ch) + OFF_MODE, 32'h0);
      wr(base(ch) + OFF_PRESC, {30'h0, code[1:0]});
      wr(OFF_CLKSEL, 32'(code[2]) << ch);
      wr(base(ch) + OFF_CMPA, {16'h0, m});
      wr(base(ch) + OFF_CMPB, {16'h0, mb});
      wr(base(ch) + OFF_OUTCTL, {24'h0, oc});
      wr(base(ch) + OFF_MODE, 32'(MODE_CLR_ON_A) << MODE_LSB);
   endtask

   task automatic wait_a(input int ch, output int at);
      at = -1;
      for (int n = 0; n < 1000 && at < 0; n++) begin
         @(negedge clk);
         if (irq_a[ch] === 1'b1) at = cyc;
      end
   endtask

   task automatic ticks(input int n);
      repeat (n) far.watch_tick();
      repeat (3) @(posedge clk);
   endtask

   // -------------------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------------------
   task automatic t_reset;
      for (int a = 0; a <= 'h4C; a += 4) rd_chk(8'(a), 32'h0, "reset or unmapped read");
      wr(8'h4C, 32'hFF);
      rd_chk(8'h4C, 32'h0, "unmapped write ignored");
      wr(OFF_COUNT, 32'h1234);
      rd_chk(OFF_COUNT, 32'h0, "count is read only");
      check({30'h0, tout}, 32'h0, "pins low after reset");
      $display("test reset done");
   endtask

   task automatic t_period(input int ch, input logic [2:0] code, input int div);
      int t0, t1;
      setup(ch, code, 16'h0002, 16'hFFFF, 8'h00);
      wait_a(ch, t0);
      wait_a(ch, t1);
      check(32'(t1 - t0), 32'(3 * div), "match period");
      $display("test period ch%0d code %0b done", ch, code);
   endtask

   task automatic t_no_clock(input int ch);
      int n0;
      setup(ch, 3'b111, 16'h0001, 16'hFFFF, 8'h00);
      n0 = far.cnt_a[ch];
      repeat (300) @(posedge clk);
      check(32'(far.cnt_a[ch] - n0), 32'h0, "match with no clock");
      rd_chk(base(ch) + OFF_COUNT, 32'h0, "count with no clock");
      $display("test no clock ch%0d done", ch);
   endtask

   task automatic t_event(input int ch);
      int n0;
      setup(ch, 3'b011, 16'h0003, 16'hFFFF, 8'h00);
      n0 = far.cnt_a[ch];
      far.event_pulses(ch, 4);
      check(32'(far.cnt_a[ch] - n0), 32'h1, "match after four edges");
      rd_chk(base(ch) + OFF_COUNT, 32'h0, "event count cleared");
      far.event_pulses(ch, 2);
      rd_chk(base(ch) + OFF_COUNT, 32'h2, "event count");
      $display("test event ch%0d done", ch);
   endtask

   task automatic t_watch;
      int n0, m0;
      setup(1, 3'b010, 16'h0004, 16'h0002, 8'h03);
      n0 = far.cnt_a[1];
      m0 = far.cnt_b[1];
      // earlier scenarios left match bits behind; start from a clean status
      wr(OFF_IRQ_STS, 32'h0F);
      ticks(3);
      rd_chk(CH_STRIDE + OFF_COUNT, 32'h3, "count after three ticks");
      check(32'(far.cnt_b[1] - m0), 32'h1, "match b in interval mode");
      ticks(2);
      rd_chk(CH_STRIDE + OFF_COUNT, 32'h0, "count cleared on match");
      check(32'(far.cnt_a[1] - n0), 32'h1, "match a raised");
      check({31'h0, tout[1]}, 32'h1, "pin toggled high");
      ticks(5);
      check({31'h0, tout[1]}, 32'h0, "pin toggled low");
      // sticky status, mask and level interrupt
      rd_chk(OFF_IRQ_STS, 32'h0C, "status after matches");
      check({31'h0, irq}, 32'h0, "interrupt masked");
      wr(OFF_IRQ_MASK, 32'h04);
      @(negedge clk);
      check({31'h0, irq}, 32'h1, "interrupt unmasked");
      wr(OFF_IRQ_STS, 32'h04);
      @(negedge clk);
      check({31'h0, irq}, 32'h0, "interrupt after clear");
      rd_chk(OFF_IRQ_STS, 32'h08, "status after clear");
      wr(OFF_IRQ_MASK, 32'h0);
      // toggling with the pin disabled, then enabled without toggling
      wr(CH_STRIDE + OFF_OUTCTL, 32'h02);
      ticks(5);
      check({31'h0, tout[1]}, 32'h0, "pin held low while disabled");
      wr(CH_STRIDE + OFF_OUTCTL, 32'h01);
      ticks(5);
      check({31'h0, tout[1]}, 32'h1, "pin kept without toggle");
      check(32'(far.cnt_a[1] - n0), 32'h4, "match a without toggle");
      // toggle on compare b, then the level set trigger
      wr(CH_STRIDE + OFF_OUTCTL, 32'h11);
      ticks(3);
      check({31'h0, tout[1]}, 32'h0, "pin toggled on match b");
      wr(CH_STRIDE + OFF_OUTCTL, 32'h09);
      ticks(0);
      check({31'h0, tout[1]}, 32'h1, "level set trigger");
      wr(CH_STRIDE + OFF_MODE, 32'h0);
      $display("test watch clock and square wave done");
   endtask

   // -------------------------------------------------------------------------
   // verdict and main sequence
   // -------------------------------------------------------------------------
   task automatic report_and_stop;
      $display("comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      for (int c = 0; c < 7; c++) begin
         if (d0[c] != 0) t_period(0, 3'(c), d0[c]);
      end
      wr(OFF_MODE, 32'h0);
      for (int c = 0; c < 7; c++) begin
         if (d1[c] != 0) t_period(1, 3'(c), d1[c]);
      end
      wr(CH_STRIDE + OFF_MODE, 32'h0);
      t_no_clock(0);
      wr(OFF_MODE, 32'h0);
      t_no_clock(1);
      wr(CH_STRIDE + OFF_MODE, 32'h0);
      t_event(0);
      wr(OFF_MODE, 32'h0);
      t_event(1);
      t_watch();
      report_and_stop();
   end

   // whole run needs under 6000 cycles; cut a hang at 20000
   initial begin
      #(200_000);
      err_count++;
      $display("watchdog expired at %0t", $time);
      report_and_stop();
   end
endmodule
